// *** src/dual_timer_consts.vh ***
// constants for the dual timer mode control block
`ifndef DUAL_TIMER_CONSTS_VH
`define DUAL_TIMER_CONSTS_VH

// register indices; the byte address is four times the index
`define IDX_MODE_SELECT      8'h01
`define IDX_ENABLE_SYNC      8'h03
`define IDX_INT_STATUS       8'h04
`define IDX_INT_MASK         8'h05

// timer_mode_select fields
`define MS_MODE_BIT          7
`define MS_SEL_BIT           6
`define MS_COMB_HI           5
`define MS_COMB_LO           4
`define MS_FUNC_HI           3
`define MS_FUNC_LO           2
`define MS_INIT8_BIT         1
`define MS_INIT16_BIT        0

// timer_enable_sync fields
`define ES_EN16_BIT          7
`define ES_EN8_BIT           6
`define ES_SYNC_BIT          5
`define ES_RSVD_VAL          5'h1f

// interrupt status and mask layout
`define ST_FALL_BIT          0
`define ST_RISE_BIT          1
`define ST_CTERM_BIT         2
`define ST_ETERM_BIT         3
`define ST_WIDTH             4

// two-bit field encodings
`define FUNC_NORMAL          2'h0
`define FUNC_PINGPONG        2'h1
`define FUNC_FORCE_LOW       2'h2
`define FUNC_FORCE_HIGH      2'h3
`define FILT_NONE            2'h0
`define FILT_SHORT           2'h1
`define FILT_LONG            2'h2
`define COMB_AND             2'h0
`define COMB_OR              2'h1
`define COMB_NOR             2'h2
`define COMB_NAND            2'h3
`define EDGE_FALL            2'h0
`define EDGE_RISE            2'h1
`define EDGE_BOTH            2'h2

// glitch filter lengths in system clock cycles
`define FILT_SHORT_CYC       4'h4
`define FILT_LONG_CYC        4'h8
`define FILT_NONE_CYC        4'h0

// reset values
`define RST_MODE_SELECT      8'h00
`define RST_STATUS           4'h0
`define RST_MASK             4'h0

`endif

// *** src/glitch_filter.v ***
// glitch filter: passes a level only after it has held for the chosen cycles
`timescale 1ns/1ps
`default_nettype none

module glitch_filter (
	input  wire       clock,
	input  wire       rst_n,
	input  wire       rawIn,
	input  wire [3:0] filtLen,
	output reg        filtOut_r
);

	reg [3:0] cnt_r;

	// count cycles that the input differs from the filtered level
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r     <= 4'h0;
			filtOut_r <= 1'b0;
		end else if (rawIn == filtOut_r) begin
			cnt_r <= 4'h0; // a short pulse that ends resets the count
		end else if (filtLen == 4'h0 || cnt_r == filtLen - 4'h1) begin
			cnt_r     <= 4'h0;
			filtOut_r <= rawIn;
		end else begin
			cnt_r <= cnt_r + 4'h1;
		end
	end

endmodule // glitch_filter

`default_nettype wire

// *** src/dual_timer_mode_control.v ***
// dual timer mode control: registers, output combining and demodulator input
// Functional notes
// [RULE_01] demod mode: falling-edge flag reads 1 after an edge, write 1 clears
// [RULE_02] demod mode: rising-edge flag reads 1 after an edge, write 1 clears
// [RULE_03] transmit: function field selects normal, ping-pong, envelope forced low/high
// [RULE_04] demod: same field selects no filter, 4-cycle, 8-cycle filter, reserved
// [RULE_05] transmit: combine field selects AND, OR, NOR, NAND of both outputs
// [RULE_06] demod: same field selects falling, rising or both edges
// [RULE_07] transmit: select bit routes combined output to the shared pin
// [RULE_08] demod: select bit picks port 3 input at 0, port 2 at 1
// [RULE_09] mode bit: 0 transmit (reset default), 1 demodulation
// [RULE_10] transmit: two bits set initial carrier and envelope output levels
// [RULE_11] sync mode aligns the first carrier pulse to the envelope counter
// [RULE_12] enable bits read running state; write 1 starts, 0 stops
// [RULE_13] input pulses narrower than the filter length are discarded
// [RULE_14] disabled carrier counter outputs the inverse of its initial level
// [RULE_15] shared pin carries the chosen combination when selected
// [RULE_16] captured edge sets its status flag and may raise an interrupt
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dual_timer_consts.vh"

module dual_timer_mode_control (
	input  wire        clock,
	input  wire        rst_n,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	input  wire [3:0]  pstrb,
	output wire        pready,
	output wire        pslverr,
	output reg  [31:0] prdata,
	input  wire        carrierTerm,
	input  wire        envelopeTerm,
	output wire        carrierRun,
	output wire        envelopeRun,
	output reg         carrierOutput,
	output reg         envelopeOutput,
	input  wire        portPinData,
	output reg         combinedOutputPin,
	input  wire        port3DemodInput,
	input  wire        port2DemodInput,
	output reg         risePulse,
	output reg         fallPulse,
	output wire        irq
);

	// byte addresses of the registers
	localparam [11:0] ADDR_MODE   = {2'b00, `IDX_MODE_SELECT, 2'b00};
	localparam [11:0] ADDR_ENSYNC = {2'b00, `IDX_ENABLE_SYNC, 2'b00};
	localparam [11:0] ADDR_STATUS = {2'b00, `IDX_INT_STATUS, 2'b00};
	localparam [11:0] ADDR_MASK   = {2'b00, `IDX_INT_MASK, 2'b00};

	// control state
	reg                  modeDemod_r;
	reg                  pinSel_r;
	reg  [1:0]           comb_r;
	reg  [1:0]           func_r;
	reg                  initCarrier_r;
	reg                  initEnvelope_r;
	reg                  riseFlag_r;
	reg                  fallFlag_r;
	reg                  enCarrier_r;
	reg                  enEnvelope_r;
	reg                  sync_r;
	reg                  syncWait_r;
	reg  [`ST_WIDTH-1:0] status_r;
	reg  [`ST_WIDTH-1:0] mask_r;
	reg                  edgePrev_r;

	// next values
	reg                  enCarrier_nxt;
	reg                  enEnvelope_nxt;
	reg                  riseFlag_nxt;
	reg                  fallFlag_nxt;
	reg  [`ST_WIDTH-1:0] status_nxt;
	reg  [3:0]           filtLen;
	reg                  combined;
	reg  [31:0]          readValue;
	reg                  addrHit;

	wire                 filtered;
	wire                 demodRaw;
	wire                 riseSeen;
	wire                 fallSeen;
	wire                 wrAccess;
	wire                 wrMode;
	wire                 wrEnSync;
	wire                 wrStatus;
	wire                 wrMask;
	wire                 pingPong;
	wire                 edgeRiseSel;
	wire                 edgeFallSel;

	// bus handshake: zero wait states, read data latched in setup
	assign pready   = 1'b1;
	assign pslverr  = psel & penable & ~addrHit;
	assign wrAccess = psel & penable & pwrite & addrHit & pstrb[0];
	assign wrMode   = wrAccess & (paddr == ADDR_MODE);
	assign wrEnSync = wrAccess & (paddr == ADDR_ENSYNC);
	assign wrStatus = wrAccess & (paddr == ADDR_STATUS);
	assign wrMask   = wrAccess & (paddr == ADDR_MASK);

	// address decode and read multiplexer
	always @* begin
		addrHit   = 1'b1;
		readValue = 32'h0000_0000;
		case (paddr)
			ADDR_MODE: begin
				readValue[`MS_MODE_BIT]              = modeDemod_r;
				readValue[`MS_SEL_BIT]               = pinSel_r;
				readValue[`MS_COMB_HI:`MS_COMB_LO]   = comb_r;
				readValue[`MS_FUNC_HI:`MS_FUNC_LO]   = func_r;
				// [RULE_02] rising flag readback
				readValue[`MS_INIT8_BIT]  = modeDemod_r ? riseFlag_r : initCarrier_r;
				// [RULE_01] falling flag readback
				readValue[`MS_INIT16_BIT] = modeDemod_r ? fallFlag_r : initEnvelope_r;
			end
			ADDR_ENSYNC: begin
				// [RULE_12] running state readback
				readValue[`ES_EN16_BIT] = enEnvelope_r;
				readValue[`ES_EN8_BIT]  = enCarrier_r;
				readValue[`ES_SYNC_BIT] = sync_r;
				readValue[4:0]          = `ES_RSVD_VAL;
			end
			ADDR_STATUS: readValue[`ST_WIDTH-1:0] = status_r;
			ADDR_MASK:   readValue[`ST_WIDTH-1:0] = mask_r;
			default:     addrHit = 1'b0;
		endcase
	end

	// read data register, loaded during the setup cycle
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= readValue;
		end
	end

	// plain configuration fields
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			modeDemod_r    <= 1'b0;
			pinSel_r       <= 1'b0;
			comb_r         <= `COMB_AND;
			func_r         <= `FUNC_NORMAL;
			initCarrier_r  <= 1'b0;
			initEnvelope_r <= 1'b0;
			sync_r         <= 1'b0;
			mask_r         <= `RST_MASK;
		end else begin
			if (wrMode) begin
				// [RULE_09] mode select
				modeDemod_r <= pwdata[`MS_MODE_BIT];
				pinSel_r    <= pwdata[`MS_SEL_BIT];
				comb_r      <= pwdata[`MS_COMB_HI:`MS_COMB_LO];
				func_r      <= pwdata[`MS_FUNC_HI:`MS_FUNC_LO];
				// [RULE_10] initial levels written
				if (!modeDemod_r) begin
					initCarrier_r  <= pwdata[`MS_INIT8_BIT];
					initEnvelope_r <= pwdata[`MS_INIT16_BIT];
				end
			end
			// [RULE_11] sync enable
			if (wrEnSync) begin
				sync_r <= pwdata[`ES_SYNC_BIT];
			end
			if (wrMask) begin
				mask_r <= pwdata[`ST_WIDTH-1:0];
			end
		end
	end

	// [RULE_03] ping-pong in transmit mode
	assign pingPong = ~modeDemod_r & (func_r == `FUNC_PINGPONG);

	// enable bits: software write, then ping-pong hand-over by hardware
	always @* begin
		enCarrier_nxt  = enCarrier_r;
		enEnvelope_nxt = enEnvelope_r;
		// [RULE_12] start and stop
		if (wrEnSync) begin
			enCarrier_nxt  = pwdata[`ES_EN8_BIT];
			enEnvelope_nxt = pwdata[`ES_EN16_BIT];
		end
		// [RULE_03] alternate enables
		if (pingPong && carrierTerm && enCarrier_r) begin
			enCarrier_nxt  = 1'b0;
			enEnvelope_nxt = 1'b1;
		end
		if (pingPong && envelopeTerm && enEnvelope_r) begin
			enEnvelope_nxt = 1'b0;
			enCarrier_nxt  = 1'b1;
		end
	end

	// enable registers and sync hold-off
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			enCarrier_r  <= 1'b0;
			enEnvelope_r <= 1'b0;
			syncWait_r   <= 1'b0;
		end else begin
			enCarrier_r  <= enCarrier_nxt;
			enEnvelope_r <= enEnvelope_nxt;
			// [RULE_11] hold carrier until envelope boundary
			if (!enCarrier_nxt) begin
				syncWait_r <= 1'b0;
			end else if (!enCarrier_r && (wrEnSync ? pwdata[`ES_SYNC_BIT] : sync_r)) begin
				syncWait_r <= 1'b1;
			end else if (envelopeTerm) begin
				syncWait_r <= 1'b0;
			end
		end
	end

	// run requests to the counting datapaths
	// [RULE_11] carrier waits for sync
	assign carrierRun  = enCarrier_r & ~syncWait_r;
	assign envelopeRun = enEnvelope_r;

	// counter output levels
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			carrierOutput  <= 1'b1;
			envelopeOutput <= 1'b1;
		end else begin
			// [RULE_14] disabled carrier level
			if (!enCarrier_nxt) begin
				carrierOutput <= ~initCarrier_r;
			end else if (!enCarrier_r) begin
				// [RULE_10] start at initial level
				carrierOutput <= initCarrier_r;
			end else if (carrierTerm && !syncWait_r) begin
				carrierOutput <= ~carrierOutput;
			end
			// [RULE_03] forced envelope levels
			if (!modeDemod_r && func_r == `FUNC_FORCE_LOW) begin
				envelopeOutput <= 1'b0;
			end else if (!modeDemod_r && func_r == `FUNC_FORCE_HIGH) begin
				envelopeOutput <= 1'b1;
			end else if (!enEnvelope_nxt) begin
				envelopeOutput <= ~initEnvelope_r;
			end else if (!enEnvelope_r) begin
				// [RULE_10] start at initial level
				envelopeOutput <= initEnvelope_r;
			end else if (envelopeTerm) begin
				envelopeOutput <= ~envelopeOutput;
			end
		end
	end

	// [RULE_05] output combining logic
	always @* begin
		case (comb_r)
			`COMB_AND: combined = carrierOutput & envelopeOutput;
			`COMB_OR:  combined = carrierOutput | envelopeOutput;
			`COMB_NOR: combined = ~(carrierOutput | envelopeOutput);
			default:   combined = ~(carrierOutput & envelopeOutput);
		endcase
	end

	// shared pin: combined timer output or ordinary port data
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			combinedOutputPin <= 1'b0;
		end else if (!modeDemod_r && pinSel_r) begin
			// [RULE_07] [RULE_15] pin carries combination
			combinedOutputPin <= combined;
		end else begin
			combinedOutputPin <= portPinData;
		end
	end

	// [RULE_08] demodulator input source
	assign demodRaw = pinSel_r ? port2DemodInput : port3DemodInput;

	// [RULE_04] filter length from the function field
	always @* begin
		case (func_r)
			`FILT_SHORT: filtLen = `FILT_SHORT_CYC;
			`FILT_LONG:  filtLen = `FILT_LONG_CYC;
			default:     filtLen = `FILT_NONE_CYC; // reserved code: no filter
		endcase
	end

	// [RULE_13] discard narrow pulses
	glitch_filter u_filter (
		.clock     (clock),
		.rst_n     (rst_n),
		.rawIn     (demodRaw),
		.filtLen   (filtLen),
		.filtOut_r (filtered)
	);

	// [RULE_06] edge selection
	assign edgeFallSel = (comb_r == `EDGE_FALL) | (comb_r == `EDGE_BOTH);
	assign edgeRiseSel = (comb_r == `EDGE_RISE) | (comb_r == `EDGE_BOTH);
	assign riseSeen    = modeDemod_r & edgeRiseSel & filtered & ~edgePrev_r;
	assign fallSeen    = modeDemod_r & edgeFallSel & ~filtered & edgePrev_r;

	// edge detector history and capture strobes
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			edgePrev_r <= 1'b0;
			risePulse  <= 1'b0;
			fallPulse  <= 1'b0;
		end else begin
			edgePrev_r <= filtered;
			risePulse  <= riseSeen;
			fallPulse  <= fallSeen;
		end
	end

	// edge flags: a new edge wins over a same-cycle clear
	always @* begin
		// [RULE_02] rising flag set and clear
		riseFlag_nxt = riseSeen |
			(riseFlag_r & ~(wrMode & modeDemod_r & pwdata[`MS_INIT8_BIT]));
		// [RULE_01] falling flag set and clear
		fallFlag_nxt = fallSeen |
			(fallFlag_r & ~(wrMode & modeDemod_r & pwdata[`MS_INIT16_BIT]));
	end

	// interrupt status: sticky, write one to clear, set wins
	always @* begin
		status_nxt = status_r;
		if (wrStatus) begin
			status_nxt = status_r & ~pwdata[`ST_WIDTH-1:0];
		end
		// [RULE_16] edge events raise status
		if (riseSeen) begin
			status_nxt[`ST_RISE_BIT] = 1'b1;
		end
		if (fallSeen) begin
			status_nxt[`ST_FALL_BIT] = 1'b1;
		end
		if (carrierTerm && enCarrier_r) begin
			status_nxt[`ST_CTERM_BIT] = 1'b1;
		end
		if (envelopeTerm && enEnvelope_r) begin
			status_nxt[`ST_ETERM_BIT] = 1'b1;
		end
	end

	// flag and status registers
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			riseFlag_r <= 1'b0;
			fallFlag_r <= 1'b0;
			status_r   <= `RST_STATUS;
		end else begin
			riseFlag_r <= riseFlag_nxt;
			fallFlag_r <= fallFlag_nxt;
			status_r   <= status_nxt;
		end
	end

	// [RULE_16] masked interrupt level
	assign irq = |(status_r & mask_r);

endmodule // dual_timer_mode_control

`default_nettype wire

// *** bench/dual_timer_props.sv ***
// port checker for the dual timer mode control
`timescale 1ns/1ps
`default_nettype none

module dual_timer_props (
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic        carrierTerm,
	input wire logic        envelopeTerm,
	input wire logic        carrierRun,
	input wire logic        envelopeRun,
	input wire logic        carrierOutput,
	input wire logic        envelopeOutput,
	input wire logic        portPinData,
	input wire logic        combinedOutputPin,
	input wire logic        risePulse,
	input wire logic        fallPulse
);
	logic [7:0] mode_r;
	logic [3:0] age_r;
	wire        wrAny = psel & penable & pwrite & pstrb[0];
	wire        wrMs  = wrAny & (paddr == 12'h004);
	wire        wrEs  = wrAny & (paddr == 12'h00c);
	wire        tx    = !mode_r[7];

	// mirror of the mode register and cycles since it was written
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mode_r <= 8'h00;
			age_r <= 4'h0;
		end else if (wrMs) begin
			mode_r[7:2] <= pwdata[7:2];
			if (tx)
				mode_r[1:0] <= pwdata[1:0];
			age_r <= 4'h0;
		end else if (age_r != 4'hf) begin
			age_r <= age_r + 4'h1;
		end
	end

	// output combination per combine code
	function automatic logic mix(input logic c, input logic e, input logic [1:0] k);
		logic t;
		t = (k == 2'h1 || k == 2'h2) ? (c | e) : (c & e);
		return t ^ k[1];
	endfunction

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence sStart8;
		wrEs && pwdata[6] && !pwdata[5] && !carrierRun && !carrierTerm && tx;
	endsequence
	sequence sSync8;
		wrEs && pwdata[6] && pwdata[5] && !carrierRun;
	endsequence

	AST_PIN_PORT: assert property ($past(rst_n && tx && !mode_r[6]) |->
		combinedOutputPin == $past(portPinData)) else $error("pin not port data");
	AST_PIN_COMB: assert property ($past(rst_n && tx && mode_r[6]) |->
		combinedOutputPin == mix($past(carrierOutput), $past(envelopeOutput),
		$past(mode_r[5:4]))) else $error("pin combination wrong");
	AST_FORCE: assert property ($past(tx && mode_r[3]) && tx && mode_r[3] &&
		$stable(mode_r[2]) |-> envelopeOutput == mode_r[2]) else $error("force wrong");
	AST_START8: assert property (sStart8 |=> carrierRun &&
		carrierOutput == $past(mode_r[1])) else $error("carrier start wrong");
	AST_OFF8: assert property (wrEs && !pwdata[6] && tx && !envelopeTerm |=>
		(!carrierRun && carrierOutput == !mode_r[1]) [*2]) else $error("carrier off wrong");
	AST_EN16: assert property (wrEs && !carrierTerm && !envelopeTerm |=>
		envelopeRun == $past(pwdata[7])) else $error("envelope enable wrong");
	AST_SYNC: assert property (sSync8 |=> !carrierRun [*3])
		else $error("carrier ran before sync");
	AST_PING: assert property (tx && mode_r[3:2] == 2'h1 && carrierRun &&
		carrierTerm && !wrEs |=> !carrierRun && envelopeRun) else $error("ping-pong wrong");
	AST_EDGE_SEL: assert property (age_r == 4'hf && !tx |->
		!(risePulse && mode_r[5:4] == 2'h0) && !(fallPulse && mode_r[5:4] == 2'h1) &&
		!(mode_r[5:4] == 2'h3 && (risePulse || fallPulse))) else $error("edge select wrong");
endmodule // dual_timer_props

`default_nettype wire

// *** bench/demod_pins.sv ***
// model of the two demodulator input pins
`timescale 1ns/1ps
`default_nettype none

module demod_pins (
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic level,
	input  wire logic useP2,
	output wire logic port3DemodInput,
	output wire logic port2DemodInput
);
	logic wander_r;

	// the unused pin keeps moving so a wrong select shows as edges
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			wander_r <= 1'b0;
		else
			wander_r <= ~wander_r;
	end
	assign port3DemodInput = useP2 ? wander_r : level;
	assign port2DemodInput = useP2 ? level : wander_r;
endmodule // demod_pins

`default_nettype wire

// *** bench/dual_timer_mode_control_tb.sv ***
// self-checking bench for the dual timer mode control
`timescale 1ns/1ps
`default_nettype none

module dual_timer_mode_control_tb;
	logic        clock, rst_n, psel, penable, pwrite, carrierTerm, envelopeTerm;
	logic        portPinData, level, useP2, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, rdat;
	logic [3:0]  pstrb;
	wire         pready, pslverr, carrierRun, envelopeRun, carrierOutput, envelopeOutput;
	wire         combinedOutputPin, port3DemodInput, port2DemodInput, risePulse, fallPulse;
	wire         irq;
	wire  [31:0] prdata;
	int          mismatches, num_checks, seed, ms, msk, flg, len;
	int          riseCnt, fallCnt, riseBase, fallBase;

	dual_timer_mode_control u_dut (
		.clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
		.pslverr, .prdata, .carrierTerm, .envelopeTerm, .carrierRun, .envelopeRun,
		.carrierOutput, .envelopeOutput, .portPinData, .combinedOutputPin,
		.port3DemodInput, .port2DemodInput, .risePulse, .fallPulse, .irq
	);
	demod_pins u_pins (.clock, .rst_n, .level, .useP2, .port3DemodInput, .port2DemodInput);

	// count capture strobes so each edge check sees its one-cycle pulse
	always @(posedge clock) begin
		if (risePulse === 1'b1)
			riseCnt++;
		if (fallPulse === 1'b1)
			fallCnt++;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one transfer, request held until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input int exp, input string what);
		apb(1'b0, a, 32'h0);
		chk(rdat, exp, what);
	endtask

	task automatic settle;
		repeat (2) @(posedge clock);
		@(negedge clock);
	endtask

	task automatic term(input logic env);
		@(posedge clock);
		envelopeTerm <= env;
		carrierTerm <= !env;
		@(posedge clock);
		envelopeTerm <= 1'b0;
		carrierTerm <= 1'b0;
		settle();
	endtask

	task automatic pulse(input int w);
		@(posedge clock);
		level <= 1'b1;
		repeat (w) @(posedge clock);
		level <= 1'b0;
		repeat (14) @(posedge clock);
	endtask

	function automatic logic mix(input logic c, input logic e, input int k);
		logic t;
		t = (k == 1 || k == 2) ? (c | e) : (c & e);
		return t ^ (k >= 2);
	endfunction

	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	initial begin
		repeat (20000) @(posedge clock);
		mismatches++;
		close_out();
	end

	initial begin
		{rst_n, psel, penable, pwrite, carrierTerm, envelopeTerm} = 6'h00;
		{portPinData, level, useP2} = 3'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'hf;
		seed = 65476;
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
		rd(12'h004, 32'h0, "modeSelect");
		rd(12'h00c, 32'h1f, "enableSync");
		apb(1'b0, 12'h008, 32'h0);
		chk(err, 1'b1, "unmappedErr");
		chk(rdat, 32'h0, "unmappedData");
		// a write without the low byte strobe is ignored
		pstrb <= 4'he;
		apb(1'b1, 12'h014, 32'hf);
		pstrb <= 4'hf;
		rd(12'h014, 32'h0, "maskStrobe");
		// every combine code over every idle level pair
		for (int k = 0; k < 16; k++) begin
			ms = 32'h40 + (k / 4) * 16 + k % 4;
			apb(1'b1, 12'h004, ms);
			rd(12'h004, ms, "modeSelect");
			chk({carrierOutput, envelopeOutput}, ~ms & 3, "idleLevels");
			chk(combinedOutputPin, mix(!ms[1], !ms[0], k / 4), "pin");
		end
		apb(1'b1, 12'h004, 32'h0);
		repeat (8) begin
			@(posedge clock);
			portPinData <= 1'($random(seed));
			settle();
			chk(combinedOutputPin, portPinData, "portPin");
		end
		for (int f = 2; f < 4; f++) begin
			apb(1'b1, 12'h004, f * 4);
			settle();
			chk(envelopeOutput, f % 2, "forced");
		end
		// carrier start, toggle and stop, then sync and ping-pong
		apb(1'b1, 12'h004, 32'h2);
		apb(1'b1, 12'h00c, 32'h40);
		settle();
		chk({carrierRun, carrierOutput}, 2'h3, "carrierStart");
		rd(12'h00c, 32'h5f, "enableSync");
		term(1'b0);
		chk(carrierOutput, 1'b0, "carrierToggle");
		// stop, then enable carrier and sync in one write
		apb(1'b1, 12'h00c, 32'h0);
		apb(1'b1, 12'h00c, 32'h60);
		settle();
		chk(carrierRun, 1'b0, "syncWait");
		term(1'b1);
		chk(carrierRun, 1'b1, "syncGo");
		apb(1'b1, 12'h00c, 32'h0);
		apb(1'b1, 12'h004, 32'h4);
		apb(1'b1, 12'h00c, 32'h40);
		term(1'b0);
		chk({carrierRun, envelopeRun}, 2'h1, "ping");
		term(1'b1);
		chk({carrierRun, envelopeRun}, 2'h2, "pong");
		apb(1'b1, 12'h00c, 32'h0);
		// each filter and edge code, both inputs, random masks
		for (int i = 0; i < 12; i++) begin
			len = (i / 4) * 4;
			ms = 32'h80 + (i % 2) * 64 + (i % 4) * 16 + (i / 4) * 4;
			msk = $random(seed) & 3;
			flg = (i % 4 == 3) ? 0 : (i % 4 != 0) * 2 + (i % 4 != 1);
			@(posedge clock);
			useP2 <= 1'(i % 2);
			apb(1'b1, 12'h004, ms);
			apb(1'b1, 12'h014, msk);
			repeat (12) @(posedge clock);
			apb(1'b1, 12'h004, ms + 3);
			apb(1'b1, 12'h010, 32'hf);
			riseBase = riseCnt;
			fallBase = fallCnt;
			if (len > 0)
				pulse(len - 1);
			rd(12'h010, 0, "narrowPulse");
			pulse(len + 3);
			rd(12'h004, ms + flg, "edgeFlags");
			chk(riseCnt - riseBase, flg / 2, "risePulses");
			chk(fallCnt - fallBase, flg % 2, "fallPulses");
			rd(12'h010, flg, "edgeStatus");
			chk(irq, (flg & msk) != 0, "irq");
			apb(1'b1, 12'h004, ms);
			rd(12'h004, ms + flg, "flagsKept");
			apb(1'b1, 12'h004, ms + 3);
			apb(1'b1, 12'h010, 32'h3);
			rd(12'h004, ms, "flagsCleared");
			chk(irq, 1'b0, "irqCleared");
		end
		close_out();
	end
endmodule // dual_timer_mode_control_tb

bind dual_timer_mode_control dual_timer_props u_props (
	.clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .carrierTerm,
	.envelopeTerm, .carrierRun, .envelopeRun, .carrierOutput, .envelopeOutput,
	.portPinData, .combinedOutputPin, .risePulse, .fallPulse
);

`default_nettype wire
